// ---- rtl/port_pin_state_gpio_pin_mux.sv ----
// Eight-pin I/O port with timer, pattern and DMA pin muxing on APB.
`timescale 1ns/1ps
module port_pin_state_gpio_pin_mux (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_n,
  input  wire logic [7:0]  timer_out,
  input  wire logic [7:0]  pattern_out,
  input  wire logic [7:0]  pattern_output_enable_high,
  input  wire logic        dma0_single_address_enable,
  input  wire logic        dma1_single_address_enable,
  input  wire logic        dma_acknowledge_0,
  input  wire logic        dma_acknowledge_1,
  input  wire logic [3:0]  chan0_mode,
  input  wire logic [3:0]  chan1_mode,
  input  wire logic [3:0]  chan2_mode,
  input  wire logic [3:0]  chan4_mode,
  input  wire logic [3:0]  chan5_mode,
  input  wire logic        buffer_op_a,
  input  wire logic        buffer_op_b,
  input  wire logic [3:0]  chan0_io_a_control,
  input  wire logic [3:0]  chan0_io_b_control,
  input  wire logic [3:0]  chan0_io_c_control,
  input  wire logic [3:0]  chan0_io_d_control,
  input  wire logic [3:0]  chan1_io_a_control,
  input  wire logic [3:0]  chan1_io_b_control,
  input  wire logic [3:0]  chan2_io_a_control,
  input  wire logic [3:0]  chan2_io_b_control,
  input  wire logic [2:0]  chan0_clear_source,
  input  wire logic [1:0]  chan1_clear_source,
  input  wire logic [1:0]  chan2_clear_source,
  input  wire logic [2:0]  chan0_prescaler_select,
  input  wire logic [2:0]  chan1_prescaler_select,
  input  wire logic [2:0]  chan2_prescaler_select,
  input  wire logic [2:0]  chan3_prescaler_select,
  input  wire logic [2:0]  chan4_prescaler_select,
  input  wire logic [2:0]  chan5_prescaler_select,
  output logic      [7:0]  capture_level,
  output logic      [7:0]  capture_enable,
  output logic      [3:0]  ext_clock_level,
  output logic      [3:0]  ext_clock_enable
);

  // ************************************************************
  // State record.
  // ************************************************************
  typedef struct packed {
    logic [7:0]  direction;
    logic [7:0]  out_data;
    logic [7:0]  sync_first;
    logic [7:0]  sync_second;
    logic [7:0]  pin_state;
    logic [7:0]  drive;
    logic [7:0]  oe_n;
    logic [7:0]  cap_en;
    logic [3:0]  clk_level;
    logic [3:0]  clk_en_bits;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [7:0] timer_owns;
  logic [7:0] cap_hit;
  logic [3:0] clk_hit;
  logic       phase_1_5;
  logic       phase_2_4;
  logic       access;
  logic [7:0] pin_view;

  // ************************************************************
  // Timer ownership helpers.
  // ************************************************************
  function automatic logic is_phase(input logic [3:0] mode);
    return mode[3:2] == port_pin_state_pkg::MODE_PHASE_HI;
  endfunction

  function automatic logic owns(input logic [3:0] mode,
                                input logic [3:0] io,
                                input logic       clr_self,
                                input logic       is_ac,
                                input logic       chan0);
    logic io_on;
    logic oc;
    io_on = io[1:0] != port_pin_state_pkg::IO_OFF_LOW;
    oc = ((mode == port_pin_state_pkg::MODE_NORMAL) || (is_phase(mode) && !chan0))
         && !io[3] && io_on;
    return oc
      || ((mode == port_pin_state_pkg::MODE_PWM2) && io_on && !clr_self)
      || ((mode == port_pin_state_pkg::MODE_PWM1) && is_ac && io_on);
  endfunction

  function automatic logic captures(input logic [3:0] mode,
                                    input logic [3:0] io,
                                    input logic       chan0);
    return ((mode == port_pin_state_pkg::MODE_NORMAL) || (is_phase(mode) && !chan0))
           && (io[3:2] == port_pin_state_pkg::IO_CAPTURE_HI);
  endfunction

  // ************************************************************
  // Pin function selection, same in every chip mode.
  // ************************************************************
  always_comb begin
    timer_owns[0] = owns(chan0_mode, chan0_io_a_control,
                         chan0_clear_source == port_pin_state_pkg::CLR0_PIN_A, 1'b1,
                         1'b1);
    timer_owns[1] = owns(chan0_mode, chan0_io_b_control,
                         chan0_clear_source == port_pin_state_pkg::CLR0_PIN_B, 1'b0,
                         1'b1);
    timer_owns[2] = owns(chan0_mode, chan0_io_c_control,
                         chan0_clear_source == port_pin_state_pkg::CLR0_PIN_C, 1'b1,
                         1'b1);
    timer_owns[3] = owns(chan0_mode, chan0_io_d_control,
                         chan0_clear_source == port_pin_state_pkg::CLR0_PIN_D, 1'b0,
                         1'b1) && !buffer_op_a && !buffer_op_b;
    timer_owns[4] = owns(chan1_mode, chan1_io_a_control,
                         chan1_clear_source == port_pin_state_pkg::CLR_PIN_A, 1'b1,
                         1'b0);
    timer_owns[5] = owns(chan1_mode, chan1_io_b_control,
                         chan1_clear_source == port_pin_state_pkg::CLR_PIN_B, 1'b0,
                         1'b0);
    timer_owns[6] = owns(chan2_mode, chan2_io_a_control,
                         chan2_clear_source == port_pin_state_pkg::CLR_PIN_A, 1'b1,
                         1'b0);
    timer_owns[7] = owns(chan2_mode, chan2_io_b_control,
                         chan2_clear_source == port_pin_state_pkg::CLR_PIN_B, 1'b0,
                         1'b0);
    cap_hit[0] = captures(chan0_mode, chan0_io_a_control, 1'b1);
    cap_hit[1] = captures(chan0_mode, chan0_io_b_control, 1'b1);
    cap_hit[2] = captures(chan0_mode, chan0_io_c_control, 1'b1);
    cap_hit[3] = captures(chan0_mode, chan0_io_d_control, 1'b1);
    cap_hit[4] = captures(chan1_mode, chan1_io_a_control, 1'b0);
    cap_hit[5] = captures(chan1_mode, chan1_io_b_control, 1'b0);
    // Channel 2 pins capture in normal or phase mode whenever the top field bit is set.
    cap_hit[6] = captures(chan2_mode, {chan2_io_a_control[3], 3'b000},
                          1'b0);
    cap_hit[7] = captures(chan2_mode, {chan2_io_b_control[3], 3'b000},
                          1'b0);
  end

  // ************************************************************
  // External clock input selection.
  // ************************************************************
  always_comb begin
    phase_1_5 = is_phase(chan1_mode) && is_phase(chan5_mode);
    phase_2_4 = is_phase(chan2_mode) && is_phase(chan4_mode);
    clk_hit[port_pin_state_pkg::CLK_D] =
      (chan0_prescaler_select == port_pin_state_pkg::PSC_CLOCK_D)
      || (chan5_prescaler_select == port_pin_state_pkg::PSC_CLOCK_D)
      || phase_2_4;
    clk_hit[port_pin_state_pkg::CLK_C] =
      (chan0_prescaler_select == port_pin_state_pkg::PSC_CLOCK_C)
      || (chan2_prescaler_select == port_pin_state_pkg::PSC_CLOCK_C)
      || (chan4_prescaler_select == port_pin_state_pkg::PSC_CLOCK_C45)
      || (chan5_prescaler_select == port_pin_state_pkg::PSC_CLOCK_C45)
      || phase_2_4;
    clk_hit[port_pin_state_pkg::CLK_B] =
      (chan0_prescaler_select == port_pin_state_pkg::PSC_CLOCK_B)
      || (chan1_prescaler_select == port_pin_state_pkg::PSC_CLOCK_B)
      || (chan2_prescaler_select == port_pin_state_pkg::PSC_CLOCK_B)
      || phase_1_5;
    clk_hit[port_pin_state_pkg::CLK_A] =
      (chan0_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || (chan1_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || (chan2_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || (chan3_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || (chan4_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || (chan5_prescaler_select == port_pin_state_pkg::PSC_CLOCK_A)
      || phase_1_5;
  end

  // ************************************************************
  // Next state.
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    access = psel && penable && state_reg.ready;
    pin_view = (state_reg.direction & state_reg.out_data)
             | (~state_reg.direction & state_reg.sync_second);
    state_next.sync_first  = pin_in;
    state_next.sync_second = state_reg.sync_first;
    state_next.pin_state   = pin_view;
    state_next.ready  = psel && !penable && !state_reg.ready;
    state_next.slverr = 1'b0;
    state_next.rdata  = port_pin_state_pkg::ZERO_WORD;
    if (psel && !penable && !state_reg.ready) begin
      case (paddr)
        port_pin_state_pkg::ADDR_DIRECTION: begin
          state_next.rdata = port_pin_state_pkg::UNDEFINED_READ;
        end
        port_pin_state_pkg::ADDR_PIN_STATE: begin
          state_next.rdata = {24'h00_0000, pin_view};
        end
        port_pin_state_pkg::ADDR_OUTPUT_DATA: begin
          state_next.rdata = {24'h00_0000, state_reg.out_data};
        end
        default: begin
          state_next.slverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      case (paddr)
        port_pin_state_pkg::ADDR_DIRECTION: begin
          state_next.direction = pwdata[7:0];
        end
        port_pin_state_pkg::ADDR_OUTPUT_DATA: begin
          state_next.out_data = pwdata[7:0];
        end
        default: begin
          state_next.out_data = state_reg.out_data;
        end
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      if (timer_owns[i]) begin
        state_next.drive[i] = timer_out[i];
        state_next.oe_n[i]  = 1'b0;
      end else if (state_reg.direction[i]) begin
        state_next.drive[i] = pattern_output_enable_high[i] ?
                              pattern_out[i] : state_reg.out_data[i];
        state_next.oe_n[i]  = 1'b0;
      end else begin
        state_next.drive[i] = 1'b0;
        state_next.oe_n[i]  = 1'b1;
      end
    end
    if (dma0_single_address_enable) begin
      state_next.drive[port_pin_state_pkg::PIN_DMA0] = dma_acknowledge_0;
      state_next.oe_n[port_pin_state_pkg::PIN_DMA0]  = 1'b0;
    end
    if (dma1_single_address_enable) begin
      state_next.drive[port_pin_state_pkg::PIN_DMA1] = dma_acknowledge_1;
      state_next.oe_n[port_pin_state_pkg::PIN_DMA1]  = 1'b0;
    end
    state_next.cap_en      = cap_hit;
    state_next.clk_en_bits = clk_hit;
    state_next.clk_level   = {state_reg.sync_second[port_pin_state_pkg::PIN_CLK_D],
                              state_reg.sync_second[port_pin_state_pkg::PIN_CLK_C],
                              state_reg.sync_second[port_pin_state_pkg::PIN_CLK_B],
                              state_reg.sync_second[port_pin_state_pkg::PIN_CLK_A]};
    if (sw_standby) begin
      state_next = state_reg;
    end
    if (hw_standby) begin
      state_next.direction = port_pin_state_pkg::DIRECTION_RESET;
      state_next.out_data  = port_pin_state_pkg::DATA_RESET;
      state_next.oe_n      = port_pin_state_pkg::OE_N_RESET;
      state_next.drive     = 8'h00;
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.oe_n <= port_pin_state_pkg::OE_N_RESET;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign prdata           = state_reg.rdata;
  assign pready           = state_reg.ready;
  assign pslverr          = state_reg.slverr;
  assign pin_out          = state_reg.drive;
  assign pin_oe_n         = state_reg.oe_n;
  assign capture_level    = state_reg.sync_second;
  assign capture_enable   = state_reg.cap_en;
  assign ext_clock_level  = state_reg.clk_level;
  assign ext_clock_enable = state_reg.clk_en_bits;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_dir_unreadable: assert property (
    (clk_en && psel && !penable && !pready && !pwrite && !sw_standby
     && paddr == port_pin_state_pkg::ADDR_DIRECTION)
    |=> (prdata == port_pin_state_pkg::UNDEFINED_READ))
    else $error("Direction read returned stored bits.");

  a_pin_state_mix: assert property (
    (clk_en && !sw_standby)
    |=> state_reg.pin_state == (($past(state_reg.direction)
         & $past(state_reg.out_data))
         | (~$past(state_reg.direction) & $past(state_reg.sync_second))))
    else $error("Pin state read mixes wrong sources.");

  a_hard_standby_clear: assert property (
    (clk_en && hw_standby)
    |=> (state_reg.direction == port_pin_state_pkg::DIRECTION_RESET
         && state_reg.out_data == port_pin_state_pkg::DATA_RESET
         && pin_oe_n == port_pin_state_pkg::OE_N_RESET))
    else $error("Hardware standby did not clear the port.");

  a_soft_standby_hold: assert property (
    (clk_en && sw_standby && !hw_standby)
    |=> ($stable(state_reg.direction) && $stable(state_reg.out_data)
         && $stable(state_reg.pin_state) && $stable(pin_out)))
    else $error("Software standby changed port state.");

  a_pin_state_nowrite: assert property (
    (clk_en && psel && penable && pready && pwrite && !sw_standby
     && !hw_standby && paddr == port_pin_state_pkg::ADDR_PIN_STATE)
    |=> ($stable(state_reg.out_data) && $stable(state_reg.direction)))
    else $error("Write to pin state altered a register.");

  a_data_write: assert property (
    (clk_en && psel && penable && pready && pwrite && !sw_standby
     && !hw_standby && paddr == port_pin_state_pkg::ADDR_OUTPUT_DATA)
    |=> (state_reg.out_data == $past(pwdata[7:0])))
    else $error("Output data write was lost.");

  a_dma1_override: assert property (
    (clk_en && dma1_single_address_enable && !sw_standby && !hw_standby)
    |=> (!pin_oe_n[port_pin_state_pkg::PIN_DMA1]
         && pin_out[port_pin_state_pkg::PIN_DMA1] == $past(dma_acknowledge_1)))
    else $error("Pin 1 is not carrying DMA acknowledge 1.");

  a_dma0_override: assert property (
    (clk_en && dma0_single_address_enable && !sw_standby && !hw_standby)
    |=> (!pin_oe_n[port_pin_state_pkg::PIN_DMA0]
         && pin_out[port_pin_state_pkg::PIN_DMA0] == $past(dma_acknowledge_0)))
    else $error("Pin 0 is not carrying DMA acknowledge 0.");

  a_input_release: assert property (
    (clk_en && !sw_standby && !hw_standby && !timer_owns[7]
     && !state_reg.direction[7])
    |=> pin_oe_n[7])
    else $error("Input pin 7 is being driven.");

  a_d_buffer_off: assert property (
    (clk_en && !sw_standby && !hw_standby && (buffer_op_a || buffer_op_b)
     && !state_reg.direction[3])
    |=> pin_oe_n[3])
    else $error("Pin D driven by timer with buffering on.");

  a_pwm2_drive: assert property (
    (clk_en && !sw_standby && !hw_standby
     && chan2_mode == port_pin_state_pkg::MODE_PWM2
     && chan2_io_b_control[1:0] != port_pin_state_pkg::IO_OFF_LOW
     && chan2_clear_source != port_pin_state_pkg::CLR_PIN_B)
    |=> (!pin_oe_n[7] && pin_out[7] == $past(timer_out[7])))
    else $error("Pin 7 lost its PWM mode 2 output.");

  a_clock_d_select: assert property (
    (clk_en && !sw_standby
     && chan5_prescaler_select == port_pin_state_pkg::PSC_CLOCK_D)
    |=> ext_clock_enable[port_pin_state_pkg::CLK_D])
    else $error("Clock D not selected on pin 7.");

  a_capture_ch0: assert property (
    (clk_en && !sw_standby && chan0_mode != port_pin_state_pkg::MODE_NORMAL)
    |=> (capture_enable[3:0] == 4'h0))
    else $error("Channel 0 capture outside normal mode.");

  a_ready_pulse: assert property (
    (clk_en && psel && !penable && !pready && !sw_standby)
    |=> pready ##1 (!pready || !$past(clk_en) || $past(sw_standby)))
    else $error("Ready pulse has the wrong length.");

  c_data_write: cover property (
    psel && penable && pready && pwrite
    && paddr == port_pin_state_pkg::ADDR_OUTPUT_DATA);
  c_pin_read: cover property (
    psel && penable && pready && !pwrite
    && paddr == port_pin_state_pkg::ADDR_PIN_STATE);
  c_pattern_drive: cover property (
    state_reg.direction[6] && pattern_output_enable_high[6]
    && !timer_owns[6]);
  c_dma_ack: cover property (dma1_single_address_enable ##1 !pin_oe_n[1]);

endmodule

// ---- rtl/port_pin_state_pkg.sv ----
// Constants, codes and reset values for the eight-pin port with pin muxing.
// Summary of operation
// - A direction bit of one makes its pin output, zero makes it input.
// - Direction register is write-only; reading it returns a fixed filler.
// - Reset and hardware standby clear direction and data; soft standby keeps.
// - Output data register is eight bits, readable and writable.
// - Pin-state read gives data bit where output, live pin where input.
// - Pin-state register ignores writes; software writes the data register.
// - Pin-state holds in soft standby, follows pins after reset or hard standby.
// - Pin functions and selection are the same in every chip mode.
// - Without timer: input, data output, or pattern output by enable bit.
// - Timer owns pin for compare output in normal mode, or phase mode on channels 1 and 2, field set.
// - Channel 1 and 2 pins carry PWM2 output unless clear selects that pin.
// - Channel 0 pins carry PWM2 output unless the clear source names them.
// - PWM1 drives the A or C pin; paired B or D output is disabled.
// - Channel 0 buffer bits disable the D pin timer output.
// - Channel 1 pins feed capture in normal or phase mode with field 10xx, channel 2 pins with field 1xxx.
// - Channel 0 pins feed capture only in normal mode with field 10xx.
// - DMA channel 1 single-address enable puts acknowledge 1 on pin 1.
// - Pin 7 feeds clock D on select 111 of channel 0 or 5, or phase 2+4.
// - Pin 5 feeds clock C on 110 of ch 0/2, 101 of ch 4/5, or phase 2+4.
// - Pin 3 feeds clock B on select 101 of channels 0 to 2, or phase 1+5.
// - Pin 2 feeds clock A on select 100 of any channel, or phase 1+5.
package port_pin_state_pkg;

  // ************************************************************
  // Register map.
  // ************************************************************
  localparam logic [15:0] ADDR_DIRECTION   = 16'hfeb0;
  localparam logic [15:0] ADDR_PIN_STATE   = 16'hff50;
  localparam logic [15:0] ADDR_OUTPUT_DATA = 16'hff60;
  localparam logic [7:0]  DIRECTION_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET       = 8'h00;
  localparam logic [31:0] UNDEFINED_READ   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [7:0]  OE_N_RESET       = 8'hff;

  // ************************************************************
  // Timer unit codes.
  // ************************************************************
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [1:0] MODE_PHASE_HI = 2'h1;
  localparam logic [3:0] MODE_PWM1     = 4'h2;
  localparam logic [3:0] MODE_PWM2     = 4'h3;
  localparam logic [1:0] IO_OFF_LOW    = 2'h0;
  localparam logic [1:0] IO_CAPTURE_HI = 2'h2;
  localparam logic [2:0] CLR0_PIN_A    = 3'h1;
  localparam logic [2:0] CLR0_PIN_B    = 3'h2;
  localparam logic [2:0] CLR0_PIN_C    = 3'h5;
  localparam logic [2:0] CLR0_PIN_D    = 3'h6;
  localparam logic [1:0] CLR_PIN_A     = 2'h1;
  localparam logic [1:0] CLR_PIN_B     = 2'h2;
  localparam logic [2:0] PSC_CLOCK_A   = 3'h4;
  localparam logic [2:0] PSC_CLOCK_B   = 3'h5;
  localparam logic [2:0] PSC_CLOCK_C   = 3'h6;
  localparam logic [2:0] PSC_CLOCK_C45 = 3'h5;
  localparam logic [2:0] PSC_CLOCK_D   = 3'h7;

  // ************************************************************
  // Pin and external clock positions.
  // ************************************************************
  localparam int PIN_DMA0  = 0;
  localparam int PIN_DMA1  = 1;
  localparam int PIN_CLK_A = 2;
  localparam int PIN_CLK_B = 3;
  localparam int PIN_CLK_C = 5;
  localparam int PIN_CLK_D = 7;
  localparam int CLK_A     = 0;
  localparam int CLK_B     = 1;
  localparam int CLK_C     = 2;
  localparam int CLK_D     = 3;

endpackage

// ---- sim/pin_partner.sv ----
// Model of external circuits that drive the port pins while released.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  // A driven pin reads back its own level; a released pin sees the outside.
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

// ---- sim/port_pin_state_gpio_pin_mux_tb.sv ----
// Self-checking bench for the eight-pin port with pin muxing.
`timescale 1ns/1ps
module port_pin_state_gpio_pin_mux_tb;
  logic        pclk = 0, presetn = 0, clk_en = 1, hw_standby = 0;
  logic        sw_standby = 0, psel = 0, penable = 0, pwrite = 0;
  logic        buffer_op_a = 0, buffer_op_b = 0, pready, pslverr, err;
  logic        dma0_single_address_enable = 0, dma1_single_address_enable = 0;
  logic        dma_acknowledge_0 = 0, dma_acknowledge_1 = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe_n, capture_level, capture_enable;
  logic [7:0]  timer_out = 8'hff, pattern_out = '0, ext_level = 8'h3c;
  logic [7:0]  pattern_output_enable_high = '0;
  logic [3:0]  chan0_mode = '0, chan1_mode = '0, chan2_mode = '0;
  logic [3:0]  chan4_mode = '0, chan5_mode = '0;
  logic [3:0]  ext_clock_level, ext_clock_enable;
  logic [3:0]  chan0_io_a_control = '0, chan0_io_b_control = '0;
  logic [3:0]  chan0_io_c_control = '0, chan0_io_d_control = '0;
  logic [3:0]  chan1_io_a_control = '0, chan1_io_b_control = '0;
  logic [3:0]  chan2_io_a_control = '0, chan2_io_b_control = '0;
  logic [2:0]  chan0_clear_source = '0, chan0_prescaler_select = '0;
  logic [2:0]  chan1_prescaler_select = '0, chan2_prescaler_select = '0;
  logic [2:0]  chan3_prescaler_select = '0, chan4_prescaler_select = '0;
  logic [2:0]  chan5_prescaler_select = '0;
  logic [1:0]  chan1_clear_source = '0, chan2_clear_source = '0;
  int          n_fail = 0, total_checks = 0, cyc = 0;

  port_pin_state_gpio_pin_mux uut (
    .pclk, .presetn, .clk_en, .hw_standby, .sw_standby, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe_n, .timer_out, .pattern_out, .pattern_output_enable_high,
    .dma0_single_address_enable, .dma1_single_address_enable,
    .dma_acknowledge_0, .dma_acknowledge_1, .chan0_mode, .chan1_mode,
    .chan2_mode, .chan4_mode, .chan5_mode, .buffer_op_a, .buffer_op_b,
    .chan0_io_a_control, .chan0_io_b_control, .chan0_io_c_control,
    .chan0_io_d_control, .chan1_io_a_control, .chan1_io_b_control,
    .chan2_io_a_control, .chan2_io_b_control, .chan0_clear_source,
    .chan1_clear_source, .chan2_clear_source, .chan0_prescaler_select,
    .chan1_prescaler_select, .chan2_prescaler_select,
    .chan3_prescaler_select, .chan4_prescaler_select,
    .chan5_prescaler_select, .capture_level, .capture_enable,
    .ext_clock_level, .ext_clock_enable);
  pin_partner far_side (.pin_out, .pin_oe_n, .ext_level, .pin_in);

  always #5 pclk = ~pclk;

  task report_and_stop;
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end

  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task settle;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    settle;
    chk(pin_oe_n, 8'hff);
    apb(0, 16'hfeb0, '0);
    chk(rd, 32'h0000_0000);
    apb(0, 16'hff60, '0);
    chk(rd, 32'h0000_0000);
    apb(1, 16'hff60, 32'h0000_00a5);
    apb(1, 16'hfeb0, 32'h0000_000f);
    apb(0, 16'hfeb0, '0);
    chk(rd, 32'h0000_0000);
    settle;
    chk(pin_oe_n, 8'hf0);
    chk(pin_out & 8'h0f, 8'h05);
    apb(0, 16'hff50, '0);
    chk(rd, 32'h0000_0035);
    apb(1, 16'hff50, 32'h0000_00ff);
    apb(0, 16'hff60, '0);
    chk(rd, 32'h0000_00a5);
    apb(0, 16'hf000, '0);
    chk(err, 1'b1);
    pattern_out <= 8'h0f;
    pattern_output_enable_high <= 8'h03;
    settle;
    chk(pin_out & 8'h0f, 8'h07);
    dma0_single_address_enable <= 1;
    dma1_single_address_enable <= 1;
    settle;
    chk(pin_out & 8'h0f, 8'h04);
    dma0_single_address_enable <= 0;
    dma1_single_address_enable <= 0;
    chan1_io_a_control <= 4'h1;
    chan0_io_d_control <= 4'h1;
    settle;
    chk({pin_oe_n[4], pin_out[4], pin_out[3]}, 3'b011);
    chan1_io_a_control <= 4'h8;
    buffer_op_a <= 1;
    settle;
    chk({pin_oe_n[4], capture_enable[4], pin_out[3]}, 3'b110);
    chk(capture_level[4], ext_level[4]);
    chan2_mode <= 4'h2;
    chan2_io_a_control <= 4'h1;
    chan2_io_b_control <= 4'h1;
    settle;
    chk(pin_oe_n[7:6], 2'b10);
    chan3_prescaler_select <= 3'h4;
    chan1_prescaler_select <= 3'h5;
    chan4_prescaler_select <= 3'h5;
    chan5_prescaler_select <= 3'h7;
    settle;
    chk(ext_clock_enable, 4'hf);
    chk(ext_clock_level, {pin_in[7], pin_in[5], pin_in[3], pin_in[2]});
    chan3_prescaler_select <= 3'h0;
    chan1_prescaler_select <= 3'h0;
    chan4_prescaler_select <= 3'h0;
    chan5_prescaler_select <= 3'h0;
    chan1_mode <= 4'h4;
    chan5_mode <= 4'h4;
    settle;
    chk(ext_clock_enable, 4'h3);
    sw_standby <= 1;
    pattern_output_enable_high <= 8'h00;
    settle;
    chk(pin_out & 8'h0f, 8'h07);
    sw_standby <= 0;
    settle;
    chk(pin_out & 8'h0f, 8'h05);
    hw_standby <= 1;
    @(posedge pclk);
    hw_standby <= 0;
    apb(0, 16'hff60, '0);
    chk(rd, 32'h0000_0000);
    chk(pin_oe_n, 8'hbf);
    chan0_mode <= 4'h3;
    chan0_io_a_control <= 4'h1;
    chan0_io_b_control <= 4'h1;
    chan0_io_c_control <= 4'h8;
    chan0_clear_source <= 3'h1;
    chan2_mode <= 4'h3;
    chan2_clear_source <= 2'h2;
    settle;
    chk(pin_oe_n, 8'hbd);
    chk(capture_enable[3:0], 4'h0);
    chan0_mode <= 4'h0;
    chan2_clear_source <= 2'h0;
    settle;
    chk(capture_enable[3:0], 4'h4);
    chk(pin_oe_n[7:6], 2'b00);
    report_and_stop;
  end
endmodule
